// >>> adc_port_defs.svh
// Constants for the byte-wide converter host port.
`ifndef ADC_PORT_DEFS_SVH
`define ADC_PORT_DEFS_SVH
`define CFG_CLK_INT_BIT 7
`define CFG_ACQ_EXT_BIT 5
`define CFG_RESET 8'h00
`define ACQ_TICKS 2'h3
`define CONV_TICKS 4'hD
`define SAR_MSB_TRIAL 12'h800
`define INT_DIV_DEFAULT 8'h03
`endif

// >>> adc_port_pkg.sv
// Types for the byte-wide converter host port.
package adc_port_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACQ = 2'b01,
    ST_CONV = 2'b11
  } conv_state_e;
  typedef struct packed {
    conv_state_e state;
    logic [7:0] cfg;
    logic ext_acq;
    logic [1:0] acq_cnt;
    logic [3:0] bit_cnt;
    logic [11:0] sar;
    logic [11:0] result;
    logic int_n;
    logic [7:0] d_out;
    logic d_oe_n;
    logic rd_prev;
    logic wr_prev;
    logic clk_prev;
    logic cs_prev;
    logic [7:0] div_cnt;
  } port_state_s;
endpackage : adc_port_pkg

// >>> adc_parallel_host_port.sv
// Parallel host port, acquisition timing and SAR sequencer of the converter.
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_defs.svh"
module adc_parallel_host_port #(
  parameter logic [7:0] INT_DIV = `INT_DIV_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic high_byte_select,
  input wire logic [7:0] d_in,
  input wire logic conv_clk,
  input wire logic cmp_hi,
  output logic [7:0] d_out,
  output logic d_oe_n,
  output logic int_n,
  output logic [11:0] dac_code,
  output logic hold,
  output logic [7:0] cfg_byte
);
  ////////////////////////////////////////////////////////////////////////////
  adc_port_pkg::port_state_s s_reg;
  adc_port_pkg::port_state_s s_next;
  logic wr_rise;
  logic rd_fall;
  logic tick;
  logic done;
  logic [11:0] trial;
  logic [3:0] step;

  // Strobe edges count only with chip select low around them.
  assign wr_rise = !s_reg.wr_prev && wr_n && !s_reg.cs_prev;
  assign rd_fall = s_reg.rd_prev && !rd_n && !cs_n;
  // Internal mode ticks from the divider; external mode on pin falling edges.
  assign tick = s_reg.cfg[`CFG_CLK_INT_BIT] ? (s_reg.div_cnt == 8'h00)
                                            : (s_reg.clk_prev && !conv_clk);
  assign step = s_reg.bit_cnt - 4'h1;
  assign trial = `SAR_MSB_TRIAL >> step;
  assign done = (s_reg.state == adc_port_pkg::ST_CONV) && tick && !wr_rise
                && (s_reg.bit_cnt == `CONV_TICKS - 4'h1);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_next = s_reg;
    s_next.rd_prev = rd_n;
    s_next.wr_prev = wr_n;
    s_next.clk_prev = conv_clk;
    s_next.cs_prev = cs_n;
    if (s_reg.div_cnt == 8'h00 || !s_reg.cfg[`CFG_CLK_INT_BIT]) begin
      s_next.div_cnt = INT_DIV - 8'h01;
    end else begin
      s_next.div_cnt = s_reg.div_cnt - 8'h01;
    end
    unique case (s_reg.state)
      adc_port_pkg::ST_IDLE: begin
      end
      adc_port_pkg::ST_ACQ: begin
        if (!s_reg.ext_acq && tick) begin
          if (s_reg.acq_cnt == `ACQ_TICKS - 2'h1) begin
            s_next.state = adc_port_pkg::ST_CONV;
            s_next.bit_cnt = 4'h0;
          end else begin
            s_next.acq_cnt = s_reg.acq_cnt + 2'h1;
          end
        end
      end
      adc_port_pkg::ST_CONV: begin
        if (tick) begin
          s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
          if (s_reg.bit_cnt == 4'h0) begin
            s_next.sar = `SAR_MSB_TRIAL;
          end else begin
            if (!cmp_hi) begin
              s_next.sar = s_reg.sar & ~trial;
            end
            if (step != 4'hB) begin
              s_next.sar = s_next.sar | (trial >> 1);
            end
          end
          if (done) begin
            s_next.result = s_next.sar;
            s_next.state = adc_port_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        s_next.state = adc_port_pkg::ST_IDLE;
      end
    endcase
    if (rd_fall) begin
      s_next.int_n = 1'b1;
    end
    if (done) begin
      s_next.int_n = 1'b0;
    end
    if (wr_rise) begin
      s_next.int_n = 1'b1;
      s_next.cfg = d_in;
      s_next.ext_acq = d_in[`CFG_ACQ_EXT_BIT];
      s_next.acq_cnt = 2'h0;
      s_next.bit_cnt = 4'h0;
      if (!d_in[`CFG_ACQ_EXT_BIT] && s_reg.state == adc_port_pkg::ST_ACQ
          && s_reg.ext_acq) begin
        s_next.state = adc_port_pkg::ST_CONV;
      end else begin
        s_next.state = adc_port_pkg::ST_ACQ;
      end
    end
    s_next.d_oe_n = cs_n || rd_n;
    s_next.d_out = high_byte_select ? {4'h0, s_reg.result[11:8]}
                                    : s_reg.result[7:0];
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '{state: adc_port_pkg::ST_IDLE, cfg: `CFG_RESET,
                 ext_acq: 1'b0, acq_cnt: 2'h0, bit_cnt: 4'h0,
                 sar: 12'h000, result: 12'h000, int_n: 1'b1,
                 d_out: 8'h00, d_oe_n: 1'b1, rd_prev: 1'b1,
                 wr_prev: 1'b1, clk_prev: 1'b0, cs_prev: 1'b1,
                 div_cnt: 8'h00};
    end else begin
      s_reg <= s_next;
    end
  end

  assign d_out = s_reg.d_out;
  assign d_oe_n = s_reg.d_oe_n;
  assign int_n = s_reg.int_n;
  assign dac_code = s_reg.sar;
  // Only the conversion state has its upper code bit set.
  assign hold = s_reg.state[1];
  assign cfg_byte = s_reg.cfg;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  sequence read_cycle;
    !cs_n && !rd_n;
  endsequence
  sequence ext_end_write;
    wr_rise && !d_in[`CFG_ACQ_EXT_BIT] && s_reg.ext_acq
      && s_reg.state == adc_port_pkg::ST_ACQ;
  endsequence
  sequence conv_tick;
    hold && tick && !wr_rise;
  endsequence

  // Read data path and bus release.
  AST_LOW_BYTE: assert property (read_cycle and !high_byte_select
      |=> d_out == $past(s_reg.result[7:0]))
    else $error("wrong low byte on bus");
  AST_NO_READ_RELEASE: assert property (!read_cycle |=> d_oe_n)
    else $error("bus driven outside a read");

  // Configuration writes and acquisition timing.
  AST_CFG_TAKEN: assert property (wr_rise |=> cfg_byte == $past(d_in))
    else $error("configuration byte not captured");
  AST_WRITE_CLEARS: assert property (wr_rise |=> int_n)
    else $error("flag not released by write");
  AST_EXT_WAITS: assert property (s_reg.state == adc_port_pkg::ST_ACQ
      && s_reg.ext_acq && !wr_rise
      |=> s_reg.state == adc_port_pkg::ST_ACQ)
    else $error("external acquisition ended without a write");
  AST_ACQ_ENDS: assert property (s_reg.state == adc_port_pkg::ST_ACQ
      && !s_reg.ext_acq && tick && !wr_rise
      && s_reg.acq_cnt == `ACQ_TICKS - 2'h1 |=> hold)
    else $error("internal acquisition did not end");
  AST_IDLE_STAY: assert property (s_reg.state == adc_port_pkg::ST_IDLE
      && !wr_rise |=> s_reg.state == adc_port_pkg::ST_IDLE)
    else $error("conversion started without a write");

  // Conversion sequencing and result capture.
  AST_SAR_START: assert property (conv_tick and s_reg.bit_cnt == 4'h0
      |=> dac_code == `SAR_MSB_TRIAL)
    else $error("first trial code wrong");
  AST_CONV_END: assert property (done |=> !hold)
    else $error("conversion did not end on last tick");
  AST_RESULT_LOAD: assert property (done
      |=> s_reg.result == $past(s_next.sar))
    else $error("result not loaded at completion");


  AST_INT_ON_DONE: assert property (done |=> !int_n)
    else $error("flag not low after conversion end");
  AST_READ_DRIVES: assert property (read_cycle |=> !d_oe_n)
    else $error("bus not driven during read");
  AST_INT_ACQ_START: assert property (wr_rise && !d_in[`CFG_ACQ_EXT_BIT]
      && s_reg.state == adc_port_pkg::ST_IDLE
      |=> s_reg.state == adc_port_pkg::ST_ACQ ##0 !hold)
    else $error("internal acquisition did not start");
  AST_EXT_CONV: assert property (ext_end_write
      |=> hold && s_reg.bit_cnt == 4'h0)
    else $error("second write did not start conversion");
  AST_CS_RELEASE: assert property (cs_n |=> d_oe_n)
    else $error("bus driven with select high");
  AST_HIGH_BYTE: assert property (read_cycle and high_byte_select
      |=> d_out == {4'h0, $past(s_reg.result[11:8])})
    else $error("wrong upper nibble on bus");
  AST_INT_CLR: assert property (rd_fall && !done |=> int_n)
    else $error("flag not released by read");
  AST_CONV_LEN: assert property (hold && !wr_rise
      && !(tick && s_reg.bit_cnt == `CONV_TICKS - 4'h1) |=> hold)
    else $error("conversion length not thirteen ticks");
  AST_ABORT: assert property (wr_rise && hold && d_in[`CFG_ACQ_EXT_BIT] == 1'b0
      |=> s_reg.state == adc_port_pkg::ST_ACQ)
    else $error("write did not abort conversion");
  AST_RESULT_HOLD: assert property (!done |=> $stable(s_reg.result))
    else $error("result changed without completion");
endmodule : adc_parallel_host_port
`default_nettype wire

// >>> adc_far_side.sv
// Analog comparator and clock pin model on the far side of the port.
`timescale 1ns/1ps
`default_nettype none
module adc_far_side #(
  parameter logic [11:0] VIN = 12'hA5C
) (
  input wire logic [11:0] dac_code,
  output logic cmp_hi,
  output logic conv_clk
);
  assign cmp_hi = (dac_code <= VIN);
  // The bench runs in internal clock mode, so the pin is tied to ground.
  assign conv_clk = 1'b0;
endmodule : adc_far_side
`default_nettype wire

// >>> adc_parallel_host_port_test.sv
// Self-checking bench for the converter host port.
`timescale 1ns/1ps
`default_nettype none
module adc_parallel_host_port_test;
  localparam logic [11:0] VIN = 12'hA5C;
  logic clk_sys, rstn, cs_n, rd_n, wr_n, high_byte_select, conv_clk, cmp_hi;
  logic [7:0] d_in, d_out, cfg_byte;
  logic d_oe_n, int_n, hold;
  logic [11:0] dac_code, v;
  int n_errors, compares, cycles, n;
  adc_parallel_host_port #(.INT_DIV(8'h02)) uut (.clk_sys(clk_sys),
    .rstn(rstn), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .high_byte_select(high_byte_select), .d_in(d_in), .conv_clk(conv_clk),
    .cmp_hi(cmp_hi), .d_out(d_out), .d_oe_n(d_oe_n), .int_n(int_n),
    .dac_code(dac_code), .hold(hold), .cfg_byte(cfg_byte));
  adc_far_side #(.VIN(VIN)) fs (.dac_code(dac_code), .cmp_hi(cmp_hi),
    .conv_clk(conv_clk));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic wrap_up();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 5000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    compares++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] b);
    @(negedge clk_sys) {cs_n, wr_n, d_in} = {2'b00, b};
    @(negedge clk_sys) wr_n = 1'b1;
    @(negedge clk_sys) cs_n = 1'b1;
  endtask : wr
  task automatic rd(input logic h, output logic [11:0] r);
    @(negedge clk_sys) {cs_n, rd_n, high_byte_select} = {2'b00, h};
    repeat (2) @(negedge clk_sys);
    chk("d_oe_n", 12'h000, {11'h000, d_oe_n});
    r = {4'h0, d_out};
    {cs_n, rd_n} = 2'b11;
    repeat (2) @(negedge clk_sys);
    chk("d_oe_n", 12'h001, {11'h000, d_oe_n});
  endtask : rd
  task automatic wait_int();
    repeat (400) if (int_n !== 1'b0) @(negedge clk_sys);
    chk("int_n", 12'h000, {11'h000, int_n});
  endtask : wait_int
  task automatic read_all();
    rd(1'b1, v);
    chk("high", {8'h00, VIN[11:8]}, v);
    chk("int_n", 12'h001, {11'h000, int_n});
    rd(1'b0, v);
    chk("low", {4'h0, VIN[7:0]}, v);
    rd(1'b1, v);
    chk("high", {8'h00, VIN[11:8]}, v);
  endtask : read_all
  task automatic t_conv();
    wr(8'h80);
    chk("cfg_byte", 12'h080, {4'h0, cfg_byte});
    repeat (40) if (hold !== 1'b1) @(negedge clk_sys);
    n = 0;
    repeat (60) if (hold === 1'b1) begin
      n++;
      @(negedge clk_sys);
    end
    chk("hold_len", 12'd26, n[11:0]);
    wait_int();
    read_all();
    $display("t_conv done");
  endtask : t_conv
  task automatic t_ext();
    wr(8'hA0);
    repeat (20) @(negedge clk_sys);
    chk("hold", 12'h000, {11'h000, hold});
    wr(8'h80);
    chk("hold", 12'h001, {11'h000, hold});
    wait_int();
    read_all();
    $display("t_ext done");
  endtask : t_ext
  task automatic t_abort();
    wr(8'h80);
    repeat (40) if (hold !== 1'b1) @(negedge clk_sys);
    wr(8'h80);
    chk("hold", 12'h000, {11'h000, hold});
    wait_int();
    wr(8'h80);
    chk("int_n", 12'h001, {11'h000, int_n});
    wait_int();
    read_all();
    $display("t_abort done");
  endtask : t_abort
  initial begin
    {rstn, cs_n, rd_n, wr_n, high_byte_select, d_in} = {5'b01110, 8'h00};
    {n_errors, compares, cycles} = 0;
    repeat (20) @(negedge clk_sys);
    rstn = 1'b1;
    t_conv();
    t_ext();
    t_abort();
    wrap_up();
  end
endmodule : adc_parallel_host_port_test
`default_nettype wire
